// ==== common/tiu_pkg.sv ====
`default_nettype none
package tiu_pkg;
  // register byte offsets
  localparam logic [7:0] TIU_OFS_SET_NMI = 8'h00;
  localparam logic [7:0] TIU_OFS_SET_T1 = 8'h04;
  localparam logic [7:0] TIU_OFS_SET_T2 = 8'h08;
  localparam logic [7:0] TIU_OFS_CNT_NMI = 8'h0c;
  localparam logic [7:0] TIU_OFS_CNT_T1 = 8'h10;
  localparam logic [7:0] TIU_OFS_CNT_T2 = 8'h14;
  localparam logic [7:0] TIU_OFS_CTRL = 8'h18;
  localparam logic [7:0] TIU_OFS_EVT_STAT = 8'h1c;
  localparam logic [7:0] TIU_OFS_EVT_MASK = 8'h20;
  // control and status field positions
  localparam int TIU_B_RUN = 0;
  localparam int TIU_B_PCI_GATE = 3;
  localparam int TIU_B_PCI_CLR = 4;
  localparam int TIU_B_PCI_PEND = 5;
  localparam int TIU_B_PEND = 8;
  localparam int TIU_B_IRQ_GATE = 12;
  localparam int TIU_B_RELOAD = 16;
  localparam int TIU_B_PRESCALE = 24;
  localparam logic [31:0] TIU_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] TIU_CTRL_WMASK = 32'h3f07_700f;
  localparam logic [31:0] TIU_CNT_TERMINAL = 32'hffff_ffff;
  localparam logic [3:0] TIU_EVT_RESET = 4'h0;
  localparam int TIU_NUM_TIMERS = 3;
  // one timer's control view
  typedef struct packed {
    logic run;
    logic reload;
    logic [1:0] prescale;
  } tiu_tmr_ctl_t;
endpackage
`default_nettype wire

// ==== rtl/tiu_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
// free-running divider giving 1, 1/2, 1/4 or 1/8 rate tick pulses
module tiu_prescaler
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // tick selection
  input wire logic [1:0] sel,
  output logic tick
);
  logic [2:0] div_q;

  // shared counter; taps make each divided rate a one-cycle pulse
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end

  always_comb
  begin
    case (sel)
      2'h0: tick = 1'b1;
      2'h1: tick = div_q[0];
      2'h2: tick = &div_q[1:0];
      default: tick = &div_q;
    endcase
  end

  // a halved rate never ticks on two cycles in a row
  half_rate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sel == 2'h1 && tick ##1 sel == 2'h1 |-> !tick)
    else $error("half rate ticked twice");
endmodule
`default_nettype wire

// ==== rtl/tiu_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// one up-counting timer with start value, reload and terminal event
module tiu_timer
  import tiu_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // control
  input wire tiu_pkg::tiu_tmr_ctl_t ctl,
  input wire logic load,
  input wire logic [31:0] load_val,
  // state
  output logic [31:0] count,
  output logic [31:0] start_val,
  output logic event_pulse
);
  logic tick;
  logic at_term;

  tiu_prescaler u_pre
  (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .sel(ctl.prescale),
    .tick(tick)
  );

  assign at_term = (count == TIU_CNT_TERMINAL);

  // start value kept for reload
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      start_val <= 32'h0000_0000;
    else if (load)
      start_val <= load_val;
  end

  // counter: a write restarts it; it halts at all ones unless reloading
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      count <= 32'h0000_0000;
    else if (load)
      count <= load_val;
    else if (ctl.run && tick)
    begin
      if (!at_term)
        count <= count + 32'h1;
      else if (ctl.reload)
        count <= start_val;
    end
  end

  // event once per arrival at terminal count
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      event_pulse <= 1'b0;
    else
      event_pulse <= !load && ctl.run && tick && (count == TIU_CNT_TERMINAL - 32'h1);
  end

  // a reloading timer restarts from the kept start value on its terminal tick
  reload_start_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ctl.run && tick && at_term && ctl.reload && !load |=> count == $past(start_val))
    else $error("reload value wrong");
  // without reload the counter parks at all ones
  term_halt_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ctl.run && tick && at_term && !ctl.reload && !load |=> at_term)
    else $error("terminal count left");
endmodule
`default_nettype wire

// ==== rtl/tiu_timer_irq.sv ====
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tiu_timer_irq
  import tiu_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pci side pins, active low, asynchronous
  input wire logic pci_inta_n,
  input wire logic pci_serr_n,
  // cpu interrupt outputs, active low
  output logic cpu_nmi_n,
  output logic cpu_int_n,
  // event-status summary interrupt
  output logic evt_irq
);
  import tiu_pkg::*;

  // the decode, pending and gate slices are written for exactly three timers
  if (TIU_NUM_TIMERS != 3)
  begin : g_bad_count
    $error("timer count must be three");
  end

  // ==========================================================
  // pin synchronisers
  logic [1:0] inta_sync_q;
  logic [1:0] serr_sync_q;
  logic inta_act;
  logic serr_act;
  logic serr_prev_q;

  // two flops each; only stage one feeds stage zero
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      inta_sync_q <= 2'h3;
      serr_sync_q <= 2'h3;
    end
    else
    begin
      inta_sync_q <= {pci_inta_n, inta_sync_q[1]};
      serr_sync_q <= {pci_serr_n, serr_sync_q[1]};
    end
  end
  assign inta_act = !inta_sync_q[0];
  assign serr_act = !serr_sync_q[0];

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      serr_prev_q <= 1'b0;
    else
      serr_prev_q <= serr_act;
  end

  // ==========================================================
  // bus address phase capture
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic take;
  logic rd_now;
  logic [7:0] rd_addr;

  assign take = hsel && hready && htrans[1];
  assign rd_now = take && !hwrite;
  assign rd_addr = haddr[7:0];
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= take && hwrite;
      wr_addr_q <= {haddr[7:2], 2'h0};
    end
  end

  // ==========================================================
  // control register and write decode
  logic [31:0] ctrl_q;
  logic [2:0] load;
  logic ctrl_wr;
  logic pci_clr_wr;

  assign ctrl_wr = wr_pend_q && (wr_addr_q == TIU_OFS_CTRL);
  assign pci_clr_wr = ctrl_wr && hwdata[TIU_B_PCI_CLR];
  assign load[0] = wr_pend_q && (wr_addr_q == TIU_OFS_SET_NMI);
  assign load[1] = wr_pend_q && (wr_addr_q == TIU_OFS_SET_T1);
  assign load[2] = wr_pend_q && (wr_addr_q == TIU_OFS_SET_T2);

  // only writable fields are stored; reserved and status bits stay zero
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_q <= TIU_CTRL_RESET;
    else if (ctrl_wr)
      ctrl_q <= hwdata & TIU_CTRL_WMASK;
  end

  // ==========================================================
  // timers
  logic [31:0] count [TIU_NUM_TIMERS];
  logic [31:0] start_val [TIU_NUM_TIMERS];
  logic [2:0] tmr_evt;

  for (genvar i = 0; i < TIU_NUM_TIMERS; i++)
  begin : g_tmr
    tiu_tmr_ctl_t ctl;
    assign ctl.run = ctrl_q[TIU_B_RUN + i];
    assign ctl.reload = ctrl_q[TIU_B_RELOAD + i];
    assign ctl.prescale = ctrl_q[TIU_B_PRESCALE + 2*i +: 2];
    tiu_timer u_tmr
    (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .ctl(ctl),
      .load(load[i]),
      .load_val(hwdata),
      .count(count[i]),
      .start_val(start_val[i]),
      .event_pulse(tmr_evt[i])
    );
  end

  // ==========================================================
  // pending flags
  logic [2:0] tmr_pend_q;
  logic pci_pend_q;
  logic stat_rd;

  assign stat_rd = rd_now && (rd_addr == TIU_OFS_CTRL);

  // set wins over the read-clear on the same edge
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      tmr_pend_q <= 3'h0;
    else
      tmr_pend_q <= (tmr_pend_q & ~{3{stat_rd}}) | tmr_evt;
  end

  // latched regardless of the gate; set wins over clear
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      pci_pend_q <= 1'b0;
    else if (inta_act)
      pci_pend_q <= 1'b1;
    else if (pci_clr_wr)
      pci_pend_q <= 1'b0;
  end

  // ==========================================================
  // cpu interrupt outputs
  logic nmi_q;
  logic int_q;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nmi_q <= 1'b0;
      int_q <= 1'b0;
    end
    else
    begin
      nmi_q <= serr_act || (tmr_pend_q[0] && ctrl_q[TIU_B_IRQ_GATE]);
      int_q <= (pci_pend_q && ctrl_q[TIU_B_PCI_GATE])
        || (|(tmr_pend_q[2:1] & ctrl_q[TIU_B_IRQ_GATE + 1 +: 2]));
    end
  end
  assign cpu_nmi_n = !nmi_q;
  assign cpu_int_n = !int_q;

  // ==========================================================
  // event status (read clears) and mask
  // bits: 0 timer terminal any, 1 serr rise, 2 inta pend, 3 unused
  logic [3:0] evt_stat_q;
  logic [3:0] evt_mask_q;
  logic [3:0] evt_set;
  logic evt_rd;

  assign evt_set = {1'b0, inta_act && !pci_pend_q, serr_act && !serr_prev_q, |tmr_evt};
  assign evt_rd = rd_now && (rd_addr == TIU_OFS_EVT_STAT);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      evt_stat_q <= TIU_EVT_RESET;
    else
      evt_stat_q <= (evt_stat_q & ~{4{evt_rd}}) | evt_set; // set beats clear
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      evt_mask_q <= TIU_EVT_RESET;
    else if (wr_pend_q && (wr_addr_q == TIU_OFS_EVT_MASK))
      evt_mask_q <= hwdata[3:0];
  end
  assign evt_irq = |(evt_stat_q & evt_mask_q);

  // ==========================================================
  // read data, registered in the data phase
  logic [31:0] stat_view;
  logic [31:0] rd_d;

  always_comb
  begin
    stat_view = ctrl_q;
    stat_view[TIU_B_PCI_PEND] = pci_pend_q;
    stat_view[TIU_B_PEND +: 3] = tmr_pend_q;
    case ({rd_addr[7:2], 2'h0})
      TIU_OFS_SET_NMI: rd_d = start_val[0];
      TIU_OFS_SET_T1: rd_d = start_val[1];
      TIU_OFS_SET_T2: rd_d = start_val[2];
      TIU_OFS_CNT_NMI: rd_d = count[0];
      TIU_OFS_CNT_T1: rd_d = count[1];
      TIU_OFS_CNT_T2: rd_d = count[2];
      TIU_OFS_CTRL: rd_d = stat_view;
      TIU_OFS_EVT_STAT: rd_d = {28'h0, evt_stat_q};
      TIU_OFS_EVT_MASK: rd_d = {28'h0, evt_mask_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      hrdata <= 32'h0000_0000;
    else if (rd_now)
      hrdata <= rd_d;
  end

  // ==========================================================
  // checks
  read_clears_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    stat_rd && !(|tmr_evt) |=> tmr_pend_q == 3'h0) else $error("pending not cleared");
  set_wins_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    stat_rd && tmr_evt[1] |=> tmr_pend_q[1]) else $error("event lost on clear");
  pci_latch_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    inta_act |=> pci_pend_q) else $error("inta not latched");
  pci_gate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    pci_pend_q && ctrl_q[TIU_B_PCI_GATE] |=> !cpu_int_n) else $error("int missing");
  serr_nmi_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    serr_act |=> !cpu_nmi_n) else $error("nmi missing on serr");
  rsvd_zero_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (ctrl_q & ~TIU_CTRL_WMASK) == 32'h0) else $error("reserved bit set");
  stop_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !ctrl_q[TIU_B_RUN + 1] && !load[1] |=> $stable(count[1])) else $error("stopped timer moved");
  load_val_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    load[2] |=> count[2] == $past(hwdata)) else $error("load value wrong");
  int_idle_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !pci_pend_q && tmr_pend_q == 3'h0 ##1 !pci_pend_q && tmr_pend_q == 3'h0
    |-> cpu_int_n) else $error("spurious int");
  // the nmi timer's event always lands in its pending flag
  evt_pend_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tmr_evt[0] |=> tmr_pend_q[0]) else $error("timer event not recorded");
  // all maskable sources gated off keep the cpu line quiet
  gate_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !ctrl_q[TIU_B_IRQ_GATE + 1] && !ctrl_q[TIU_B_IRQ_GATE + 2] && !ctrl_q[TIU_B_PCI_GATE]
    |=> cpu_int_n) else $error("ungated int");
  // gated nonmaskable timer pending reaches the nmi line
  nmi_timer_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tmr_pend_q[0] && ctrl_q[TIU_B_IRQ_GATE] |=> !cpu_nmi_n) else $error("nmi timer lost");
  // with no source the nmi line stays released
  nmi_idle_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !serr_act && !(tmr_pend_q[0] && ctrl_q[TIU_B_IRQ_GATE]) |=> cpu_nmi_n)
    else $error("spurious nmi");
  // a clear with the pin released empties the latch
  pci_clear_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    pci_clr_wr && !inta_act |=> !pci_pend_q) else $error("inta not cleared");
  // the latch holds until software clears it
  pci_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    pci_pend_q && !pci_clr_wr |=> pci_pend_q) else $error("inta latch dropped");
  // reserved and write-only positions always read zero
  rsvd_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (stat_view & 32'hc0f8_88d0) == 32'h0) else $error("reserved bit reads one");
  // counter reads return the count seen in the address phase
  cnt_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rd_now && rd_addr == TIU_OFS_CNT_T2 |=> hrdata == $past(count[2]))
    else $error("count read wrong");
  // a serr assertion is recorded in the event status
  serr_evt_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    evt_set[1] |=> evt_stat_q[1]) else $error("serr event lost");
endmodule
`default_nettype wire

// ==== test/tiu_pci_agent.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// pci agent standing on the interrupt pins
module tiu_pci_agent
(
  // clock
  input wire logic ref_clk,
  // open-drain pins, pulled up when released
  output logic inta_n,
  output logic serr_n
);
  // released lines sit at the pull-up level, never at a stale value
  initial
  begin
    inta_n = 1'b1;
    serr_n = 1'b1;
  end

  // pins move just after an edge so the synchroniser sees a clean level
  task automatic drive(input logic inta, input logic serr);
    @(posedge ref_clk);
    inta_n <= ~inta;
    serr_n <= ~serr;
  endtask
endmodule
`default_nettype wire

// ==== test/timer_interrupt_unit_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// register-level bench for the timer and interrupt unit
module timer_interrupt_unit_tb_top;
  import tiu_pkg::*;
  logic ref_clk = 0, arst_n = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, c;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  wire logic hready, hreadyout, hresp, cpu_nmi_n, cpu_int_n, evt_irq, inta_n, serr_n;
  wire logic [31:0] hrdata;
  int miscompares = 0, compares = 0, cyc = 0, n, t, p;
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  tiu_timer_irq dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pci_inta_n(inta_n),
    .pci_serr_n(serr_n), .cpu_nmi_n(cpu_nmi_n), .cpu_int_n(cpu_int_n), .evt_irq(evt_irq));
  tiu_pci_agent pci_u (.ref_clk(ref_clk), .inta_n(inta_n), .serr_n(serr_n));

  always #2 ref_clk = ~ref_clk;

  // ==========================================
  // hang guard, far above the fewer than a thousand cycles the tests need
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  // ==========================================
  // one ahb-lite single word transfer, waits on ready with no assumed latency
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
    // let registered outputs launched on this edge settle before callers look
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t pin %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int k, input int lo, input int hi);
    compares++;
    if (k < lo || k > hi)
    begin
      miscompares++;
      $display("ERROR %0t delay %0d outside %0d..%0d", $time, k, lo, hi);
    end
  endtask

  // counts cycles until the chosen interrupt pin reaches a level, bounded
  task automatic wait_pin(input logic nmi, input logic lvl, output int k);
    k = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    while (((nmi ? cpu_nmi_n : cpu_int_n) !== lvl) && k < 300);
  endtask

  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    bus(0, TIU_OFS_CTRL, 0);
    chk(rd, 32'h0);
    bus(0, TIU_OFS_EVT_MASK, 0);
    chk(rd, 32'h0);
    bus(0, 8'h40, 0);
    chk(rd, 32'h0);
    chk_pin(hresp, 1'b0);
    bus(1, TIU_OFS_CTRL, 32'hffff_ffff);
    bus(0, TIU_OFS_CTRL, 0);
    chk(rd, 32'h3f07_700f);
    bus(1, TIU_OFS_CTRL, 0);
    $display("test reset_values done");
    // every timer at every rate: 7 ticks from the start value to all ones
    for (t = 0; t < 3; t++)
      for (p = 0; p < 4; p++)
      begin
        c = (32'h1 << t) | (32'h1 << (12 + t)) | (32'(p) << (24 + 2 * t));
        bus(1, TIU_OFS_SET_NMI + 8'(4 * t), 32'hffff_fff8);
        bus(1, TIU_OFS_CTRL, c);
        wait_pin(t == 0, 1'b0, n);
        chk_rng(n, (6 << p) + 2, (7 << p) + 8);
        bus(0, TIU_OFS_CTRL, 0);
        chk(rd, c | (32'h100 << t));
        bus(0, TIU_OFS_CTRL, 0);
        chk(rd, c);
        chk_pin(t == 0 ? cpu_nmi_n : cpu_int_n, 1'b1);
        bus(0, TIU_OFS_CNT_NMI + 8'(4 * t), 0);
        chk(rd, 32'hffff_ffff);
        bus(1, TIU_OFS_CTRL, 0);
      end
    $display("test timer_rates done");
    // reload with the gate off: the event must stay off the cpu pin
    c = 32'h0c02_0002;
    bus(1, TIU_OFS_SET_T1, 32'hffff_fffc);
    bus(1, TIU_OFS_CTRL, c);
    n = 0;
    do
    begin
      bus(0, TIU_OFS_CTRL, 0);
      n++;
    end
    while (rd[9] !== 1'b1 && n < 60);
    chk(rd, c | 32'h200);
    chk_pin(cpu_int_n, 1'b1);
    do
    begin
      bus(0, TIU_OFS_CNT_T1, 0);
      n++;
    end
    while (rd !== 32'hffff_fffc && n < 120);
    chk(rd, 32'hffff_fffc);
    bus(1, TIU_OFS_CTRL, 0);
    bus(0, TIU_OFS_CNT_T1, 0);
    c = rd;
    bus(1, TIU_OFS_CNT_T1, 32'h0);
    bus(0, TIU_OFS_CNT_T1, 0);
    chk(rd, c);
    $display("test reload done");
    // inta latched while ungated, then gated, then cleared
    pci_u.drive(1'b1, 1'b0);
    n = 0;
    do
    begin
      bus(0, TIU_OFS_CTRL, 0);
      n++;
    end
    while (rd[5] !== 1'b1 && n < 20);
    chk(rd, 32'h20);
    chk_pin(cpu_int_n, 1'b1);
    pci_u.drive(1'b0, 1'b0);
    bus(1, TIU_OFS_CTRL, 32'h8);
    wait_pin(1'b0, 1'b0, n);
    chk_rng(n, 0, 4);
    bus(1, TIU_OFS_CTRL, 32'h8);
    bus(0, TIU_OFS_CTRL, 0);
    chk(rd, 32'h28);
    bus(1, TIU_OFS_CTRL, 32'h18);
    bus(0, TIU_OFS_CTRL, 0);
    chk(rd, 32'h8);
    chk_pin(cpu_int_n, 1'b1);
    bus(1, TIU_OFS_CTRL, 0);
    $display("test pci_inta done");
    // sticky event status, mask and the summary interrupt
    bus(0, TIU_OFS_EVT_STAT, 0);
    chk(rd, 32'h5);
    bus(0, TIU_OFS_EVT_STAT, 0);
    chk(rd, 32'h0);
    pci_u.drive(1'b0, 1'b1);
    wait_pin(1'b1, 1'b0, n);
    chk_rng(n, 1, 6);
    chk_pin(evt_irq, 1'b0);
    bus(1, TIU_OFS_EVT_MASK, 32'h2);
    chk_pin(evt_irq, 1'b1);
    bus(0, TIU_OFS_EVT_MASK, 0);
    chk(rd, 32'h2);
    bus(0, TIU_OFS_EVT_STAT, 0);
    chk(rd, 32'h2);
    chk_pin(evt_irq, 1'b0);
    pci_u.drive(1'b0, 1'b0);
    wait_pin(1'b1, 1'b1, n);
    chk_rng(n, 1, 6);
    $display("test serr_events done");
    end_of_test();
  end
endmodule
`default_nettype wire
